/* File: hw/pwe_consts.svh */
// Register offsets, field positions, reset values and counts of the waveform engine
`ifndef PWE_CONSTS_SVH
`define PWE_CONSTS_SVH

// Register byte offsets
`define PWE_OFS_CTRL         8'h00
`define PWE_OFS_STATUS       8'h04
`define PWE_OFS_COUNT        8'h08
`define PWE_OFS_PORTCFG      8'h0C
`define PWE_OFS_PINS         8'h10
`define PWE_OFS_ADDR_START   8'h14
`define PWE_OFS_CODE_RESTART 8'h18
`define PWE_OFS_CODE_FIRST   8'h1C
`define PWE_OFS_CODE_SECOND  8'h20

// Control register fields
`define PWE_CTRL_GO          0
`define PWE_CTRL_DESC_LSB    1
`define PWE_CTRL_WORD_WIDE   3
`define PWE_CTRL_CODE_MODE   4
`define PWE_CTRL_MODE_LSB    5
`define PWE_CTRL_IDLE_LSB    8

// Port configuration fields
`define PWE_PORT_C_OUT_LSB   0
`define PWE_PORT_C_OE_LSB    8
`define PWE_PORT_D_OUT_LSB   16
`define PWE_PORT_D_OE_LSB    24

// Reset values
`define PWE_RST_IDLE_CTRL    6'h3F
`define PWE_RST_PORTCFG      32'h0000_0000
`define PWE_RST_ALT_SELECT   8'h00

// Last byte index of each code block
`define PWE_CODE_SMALL_LAST  8'hFF
`define PWE_CODE_LARGE_LAST  9'h1FF

`endif

/* File: hw/pwe_engine.sv */
// Programmable waveform engine with transfer counter and byte error-code generator
//
// How it works
// - Parallel data bus runs 8 or 16 bits wide, set by word_wide.
// - Six control outputs, nine address outputs, six ready inputs.
// - Each state vector sets all control levels and a ready condition.
// - A vector can advance the buffer data and increment the address.
// - Ordered vectors up to one marked last form one waveform, one transaction.
// - Control outputs may change every interface clock cycle.
// - Ready inputs are sampled and decide whether the waveform advances.
// - Nine address bits index up to 512 bytes; more need port pins.
// - A 32-bit count in four byte lanes runs long unattended transfers.
// - Data movement stalls while the buffers cannot serve, then resumes.
// - The count decrements per finished transaction and reads back remaining.
// - Codes cover bytes from the engine or the slave buffer interface.
// - Code generation runs only in byte-wide mode.
// - Codes correct one-bit errors and detect two-bit errors per block.
// - Mode bit clear: two 3-byte codes over two 256-byte blocks.
// - Writing the restart register restarts; first block first, second next.
// - After the last code, results hold until the next restart.
// - Mode bit set: one 3-byte code over one 512-byte block.
// - Port C pins carry address bits when their alternate select is set.
// - Port D carries upper data in master mode with word_wide set.
// - State vectors live in a 128-byte memory of four descriptors.
// - All engine timing runs on the interface clock, here core_clk.
`include "pwe_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pwe_engine #(
  parameter int ADDR_W  = 9,
  parameter int COUNT_W = 32
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // Avalon-MM slave
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic      [5:0]          ctrl_out,
  input  wire logic [5:0]          rdy_in,
  output logic      [ADDR_W-1:0]   wave_addr_out,
  // Data bus pins, upper byte shared with port D
  input  wire logic [15:0]         fifo_data_bus_in,
  output logic      [15:0]         fifo_data_bus_out,
  output logic      [15:0]         fifo_data_bus_oe,
  // Port C pins
  input  wire logic [7:0]          port_c_in,
  output logic      [7:0]          port_c_out,
  output logic      [7:0]          port_c_oe,
  // Endpoint buffer toward the device
  input  wire logic [15:0]         src_data,
  input  wire logic                src_valid,
  output logic                     src_pop,
  // Endpoint buffer from the device
  output logic      [15:0]         snk_data,
  output logic                     snk_push,
  input  wire logic                snk_ready,
  // Bytes crossing the slave buffer interface
  input  wire logic [7:0]          slave_byte,
  input  wire logic                slave_byte_valid
);

  if (ADDR_W != 9 || COUNT_W < 1 || COUNT_W > 32) begin : g_param_check
    $error("pwe_engine: ADDR_W must be 9 and COUNT_W 1 to 32");
  end

  logic [31:0]          wave_mem [32];
  pwe_pkg::pwe_state_t  state_reg;
  logic [2:0]           pc_reg;
  logic [COUNT_W-1:0]   count_reg;
  logic                 done_reg;
  logic [ADDR_W-1:0]    addr_start_reg;
  logic [1:0]           desc_sel_reg;
  logic                 word_wide_reg;
  logic                 code_mode_reg;
  logic [1:0]           iface_mode_reg;
  logic [5:0]           idle_ctrl_reg;
  logic [31:0]          portcfg_reg;
  logic [7:0]           alt_select_reg;
  logic [15:0]          data_out_reg;
  logic [23:0]          code_first_reg;
  logic [23:0]          code_second_reg;
  logic [31:0]          rdata_next;
  pwe_pkg::pwe_vec_t    vec;
  logic                 eng_run;
  logic                 rdy_met;
  logic                 data_ok;
  logic                 step;
  logic                 bus_wr;
  logic                 go;
  logic                 restart;
  logic                 upper_data;
  logic                 master_mode;

  assign bus_wr      = avs_write && !avs_waitrequest;
  assign master_mode = iface_mode_reg == pwe_pkg::PWE_MODE_MASTER;
  assign upper_data  = master_mode && word_wide_reg;
  assign go          = bus_wr && avs_address == `PWE_OFS_CTRL && avs_byteenable[0]
                       && avs_writedata[`PWE_CTRL_GO] && master_mode
                       && state_reg == pwe_pkg::PWE_ST_IDLE && count_reg != '0;
  assign restart     = bus_wr && avs_address == `PWE_OFS_CODE_RESTART;

  assign vec     = pwe_pkg::pwe_vec_t'(wave_mem[{desc_sel_reg, pc_reg}]);
  assign eng_run = state_reg == pwe_pkg::PWE_ST_RUN;
  assign rdy_met = ((rdy_in ^ vec.rdy_val) & vec.rdy_mask) == 6'h00;
  // stall on buffers, and for the cycle each strobe is high, for the buffer to settle
  assign data_ok = !vec.advance || (!src_pop && !snk_push
                   && (vec.drive ? src_valid : snk_ready));
  assign step    = eng_run && rdy_met && data_ok;

  // Avalon handshake: one wait cycle, then a single-cycle answer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rdata_next : 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (avs_address[7]) begin
      rdata_next = wave_mem[avs_address[6:2]];
    end else begin
      case (avs_address)
        `PWE_OFS_CTRL:        rdata_next = {18'h00000, idle_ctrl_reg, 1'b0, iface_mode_reg,
                                            code_mode_reg, word_wide_reg, desc_sel_reg, 1'b0};
        `PWE_OFS_STATUS:      rdata_next = {27'h0000000, pc_reg, done_reg, eng_run};
        `PWE_OFS_COUNT:       rdata_next = 32'(count_reg);
        `PWE_OFS_PORTCFG:     rdata_next = portcfg_reg;
        `PWE_OFS_PINS:        rdata_next = {8'h00, alt_select_reg, fifo_data_bus_in[15:8],
                                            port_c_in};
        `PWE_OFS_ADDR_START:  rdata_next = 32'(addr_start_reg);
        `PWE_OFS_CODE_FIRST:  rdata_next = {8'h00, code_first_reg};
        `PWE_OFS_CODE_SECOND: rdata_next = {8'h00, code_second_reg};
        default:              rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Waveform memory writes; no reset, software loads it before use
  always_ff @(posedge core_clk) begin
    if (bus_wr && avs_address[7]) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          wave_mem[avs_address[6:2]][b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      desc_sel_reg   <= 2'h0;
      word_wide_reg  <= 1'b0;
      code_mode_reg  <= 1'b0;
      iface_mode_reg <= pwe_pkg::PWE_MODE_PORTS;
      idle_ctrl_reg  <= `PWE_RST_IDLE_CTRL;
      portcfg_reg    <= `PWE_RST_PORTCFG;
      alt_select_reg <= `PWE_RST_ALT_SELECT;
      addr_start_reg <= '0;
    end else if (bus_wr) begin
      if (avs_address == `PWE_OFS_CTRL && avs_byteenable[0]) begin
        desc_sel_reg   <= avs_writedata[`PWE_CTRL_DESC_LSB +: 2];
        word_wide_reg  <= avs_writedata[`PWE_CTRL_WORD_WIDE];
        code_mode_reg  <= avs_writedata[`PWE_CTRL_CODE_MODE];
        iface_mode_reg <= avs_writedata[`PWE_CTRL_MODE_LSB +: 2];
      end
      if (avs_address == `PWE_OFS_CTRL && avs_byteenable[1]) begin
        idle_ctrl_reg <= avs_writedata[`PWE_CTRL_IDLE_LSB +: 6];
      end
      if (avs_address == `PWE_OFS_PORTCFG) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            portcfg_reg[b*8 +: 8] <= avs_writedata[b*8 +: 8];
          end
        end
      end
      if (avs_address == `PWE_OFS_PINS && avs_byteenable[2]) begin
        alt_select_reg <= avs_writedata[23:16];
      end
      if (avs_address == `PWE_OFS_ADDR_START) begin
        addr_start_reg <= avs_writedata[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= pwe_pkg::PWE_ST_IDLE;
      pc_reg    <= 3'h0;
      done_reg  <= 1'b0;
    end else begin
      case (state_reg)
        pwe_pkg::PWE_ST_IDLE: begin
          if (go) begin
            state_reg <= pwe_pkg::PWE_ST_RUN;
            pc_reg    <= 3'h0;
            done_reg  <= 1'b0;
          end
        end
        pwe_pkg::PWE_ST_RUN: begin
          if (step && vec.last) begin
            pc_reg <= 3'h0;
            if (count_reg == COUNT_W'(1)) begin
              state_reg <= pwe_pkg::PWE_ST_IDLE;
              done_reg  <= 1'b1;
            end
          end else if (step) begin
            pc_reg <= pc_reg + 3'h1;
          end
        end
        default: state_reg <= pwe_pkg::PWE_ST_IDLE;
      endcase
    end
  end

  // transaction count, byte lanes b0 to b3
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (step && vec.last) begin
      count_reg <= count_reg - COUNT_W'(1);
    end else if (bus_wr && avs_address == `PWE_OFS_COUNT && !eng_run) begin
      logic [31:0] tmp;
      tmp = 32'(count_reg);
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          tmp[b*8 +: 8] = avs_writedata[b*8 +: 8];
        end
      end
      count_reg <= tmp[COUNT_W-1:0];
    end
  end

  // control levels follow the vector every running cycle, idle levels otherwise
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_out <= `PWE_RST_IDLE_CTRL;
    end else begin
      ctrl_out <= eng_run ? vec.ctrl : idle_ctrl_reg;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wave_addr_out <= '0;
    end else if (go) begin
      wave_addr_out <= addr_start_reg;
    end else if (step && vec.incr_addr) begin
      wave_addr_out <= wave_addr_out + ADDR_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      src_pop      <= 1'b0;
      snk_push     <= 1'b0;
      snk_data     <= 16'h0000;
      data_out_reg <= 16'h0000;
    end else begin
      src_pop  <= step && vec.advance && vec.drive;
      snk_push <= step && vec.advance && !vec.drive;
      if (step && vec.advance && vec.drive) begin
        data_out_reg <= src_data;
      end
      if (step && vec.advance && !vec.drive) begin
        snk_data <= upper_data ? fifo_data_bus_in : {8'h00, fifo_data_bus_in[7:0]};
      end
    end
  end

  // data pins; upper byte is port D unless word-wide master
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_data_bus_out <= 16'h0000;
      fifo_data_bus_oe  <= 16'h0000;
    end else begin
      fifo_data_bus_out[7:0] <= (step && vec.advance && vec.drive) ? src_data[7:0]
                                                                    : data_out_reg[7:0];
      fifo_data_bus_oe[7:0]  <= {8{eng_run && vec.drive}};
      if (upper_data) begin
        fifo_data_bus_out[15:8] <= (step && vec.advance && vec.drive) ? src_data[15:8]
                                                                       : data_out_reg[15:8];
        fifo_data_bus_oe[15:8]  <= {8{eng_run && vec.drive}};
      end else begin
        fifo_data_bus_out[15:8] <= portcfg_reg[`PWE_PORT_D_OUT_LSB +: 8];
        fifo_data_bus_oe[15:8]  <= portcfg_reg[`PWE_PORT_D_OE_LSB +: 8];
      end
    end
  end

  // port C alternate function; address lags the engine by one cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port_c_out <= 8'h00;
      port_c_oe  <= 8'h00;
    end else begin
      for (int k = 0; k < 8; k++) begin
        port_c_out[k] <= alt_select_reg[k] ? wave_addr_out[k]
                                           : portcfg_reg[`PWE_PORT_C_OUT_LSB + k];
        port_c_oe[k]  <= alt_select_reg[k] | portcfg_reg[`PWE_PORT_C_OE_LSB + k];
      end
    end
  end

  // Error-code generator
  pwe_pkg::pwe_acc_t acc_reg;
  pwe_pkg::pwe_acc_t acc_next;
  logic [9:0]        code_cnt_reg;
  logic              code_frozen_reg;
  logic [7:0]        code_byte;
  logic              code_en;
  logic [8:0]        code_idx;
  logic              block_end;
  logic              eng_byte;

  // engine bytes first, slave bytes when the engine moves none
  assign eng_byte  = step && vec.advance;
  assign code_byte = eng_byte ? (vec.drive ? src_data[7:0] : fifo_data_bus_in[7:0])
                              : slave_byte;
  assign code_en   = !word_wide_reg && !code_frozen_reg && (eng_byte || slave_byte_valid);
  assign code_idx  = code_mode_reg ? code_cnt_reg[8:0] : {1'b0, code_cnt_reg[7:0]};
  assign block_end = code_mode_reg ? code_cnt_reg[8:0] == `PWE_CODE_LARGE_LAST
                                   : code_cnt_reg[7:0] == `PWE_CODE_SMALL_LAST;

  // line parity per index bit, column parity per bit group
  always_comb begin
    acc_next = acc_reg;
    for (int k = 0; k < 9; k++) begin
      if (^code_byte) begin
        if (code_idx[k]) begin
          acc_next.lp_odd[k] = ~acc_reg.lp_odd[k];
        end else begin
          acc_next.lp_even[k] = ~acc_reg.lp_even[k];
        end
      end
    end
    acc_next.cp[0] = acc_reg.cp[0] ^ code_byte[6] ^ code_byte[4] ^ code_byte[2] ^ code_byte[0];
    acc_next.cp[1] = acc_reg.cp[1] ^ code_byte[7] ^ code_byte[5] ^ code_byte[3] ^ code_byte[1];
    acc_next.cp[2] = acc_reg.cp[2] ^ code_byte[5] ^ code_byte[4] ^ code_byte[1] ^ code_byte[0];
    acc_next.cp[3] = acc_reg.cp[3] ^ code_byte[7] ^ code_byte[6] ^ code_byte[3] ^ code_byte[2];
    acc_next.cp[4] = acc_reg.cp[4] ^ (^code_byte[3:0]);
    acc_next.cp[5] = acc_reg.cp[5] ^ (^code_byte[7:4]);
  end

  // Interleave even and odd line parity, pack with columns, inverted as stored
  function automatic logic [23:0] pwe_code_fmt(input pwe_pkg::pwe_acc_t a, input logic wide);
    logic [17:0] lp;
    for (int k = 0; k < 9; k++) begin
      lp[2*k]   = a.lp_even[k];
      lp[2*k+1] = a.lp_odd[k];
    end
    return ~{a.cp, wide ? lp[17:16] : 2'b00, lp[15:0]};
  endfunction : pwe_code_fmt

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg         <= '0;
      code_cnt_reg    <= 10'h000;
      code_frozen_reg <= 1'b0;
      code_first_reg  <= 24'h000000;
      code_second_reg <= 24'h000000;
    end else if (restart) begin
      acc_reg         <= '0;
      code_cnt_reg    <= 10'h000;
      code_frozen_reg <= 1'b0;
      code_first_reg  <= 24'h000000;
      code_second_reg <= 24'h000000;
    end else if (code_en) begin
      code_cnt_reg <= code_cnt_reg + 10'h001;
      acc_reg      <= block_end ? '0 : acc_next;
      if (block_end) begin
        if (code_mode_reg) begin
          code_first_reg  <= pwe_code_fmt(acc_next, 1'b1);
          code_frozen_reg <= 1'b1;
        end else if (!code_cnt_reg[8]) begin
          code_first_reg <= pwe_code_fmt(acc_next, 1'b0);
        end else begin
          code_second_reg <= pwe_code_fmt(acc_next, 1'b0);
          code_frozen_reg <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  ctrl_follow_a: assert property (eng_run |=> ctrl_out == $past(vec.ctrl))
    else $error("control levels do not follow the vector");
  hold_unmet_a: assert property ((eng_run && !step) |=> eng_run && pc_reg == $past(pc_reg))
    else $error("state moved with ready condition unmet");
  ready_branch_a: assert property ((eng_run && !rdy_met) |-> !step)
    else $error("advanced without ready match");
  buffer_stall_a: assert property ((eng_run && vec.advance && vec.drive && !src_valid) |-> !step)
    else $error("advanced with empty buffer");
  count_dec_a: assert property ((step && vec.last) |=> count_reg == $past(count_reg) - COUNT_W'(1))
    else $error("count not decremented");
  wave_end_a: assert property ((step && vec.last && count_reg == COUNT_W'(1)) |=> !eng_run && done_reg)
    else $error("engine did not stop after last transaction");
  addr_step_a: assert property ((step && vec.incr_addr && !go) |=> wave_addr_out == $past(wave_addr_out) + ADDR_W'(1))
    else $error("address did not increment");
  pop_pulse_a: assert property ((step && vec.advance && vec.drive) |=> src_pop ##1 !src_pop)
    else $error("pop strobe not a single pulse");
  code_byte_a: assert property (word_wide_reg |-> !code_en)
    else $error("code computed in word mode");
  code_hold_a: assert property ((code_frozen_reg && !restart) |=> $stable(code_first_reg) && $stable(code_second_reg))
    else $error("code results changed while frozen");
  code_restart_a: assert property (restart |=> code_cnt_reg == 10'h000 && !code_frozen_reg)
    else $error("restart did not clear the generator");

  wave_done_c: cover property (eng_run && step && vec.last && count_reg == COUNT_W'(1));
  multi_xfer_c: cover property (step && vec.last && count_reg > COUNT_W'(1));
  stall_c: cover property (eng_run && rdy_met && !data_ok);
  code_frozen_c: cover property (!code_frozen_reg ##1 code_frozen_reg);

endmodule : pwe_engine

`default_nettype wire

/* File: hw/pwe_pkg.sv */
// Types shared by the waveform engine
package pwe_pkg;

  typedef enum logic [1:0] {
    PWE_ST_IDLE = 2'b01,
    PWE_ST_RUN  = 2'b10
  } pwe_state_t;

  typedef enum logic [1:0] {
    PWE_MODE_PORTS  = 2'h0,
    PWE_MODE_MASTER = 2'h2,
    PWE_MODE_SLAVE  = 2'h3
  } pwe_mode_t;

  // One state vector, one word of waveform memory
  typedef struct packed {
    logic [9:0] spare;
    logic       last;
    logic       drive;
    logic       incr_addr;
    logic       advance;
    logic [5:0] rdy_val;
    logic [5:0] rdy_mask;
    logic [5:0] ctrl;
  } pwe_vec_t;

  // Running parity of one code block
  typedef struct packed {
    logic [8:0] lp_odd;
    logic [8:0] lp_even;
    logic [5:0] cp;
  } pwe_acc_t;

endpackage : pwe_pkg

/* File: verif/programmable_waveform_master_ecc_test.sv */
// Self-checking bench for the waveform engine and its code generator
`timescale 1ns/1ps
`default_nettype none
module programmable_waveform_master_ecc_test;
  logic core_clk, resetn, avs_read, avs_write, avs_waitrequest, src_pop, snk_push, slave_byte_valid;
  logic [7:0]  avs_address, slave_byte;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [5:0]  ctrl_out, rdy_in;
  logic [8:0]  wave_addr_out;
  logic [15:0] bus_in, bus_out, bus_oe, snk_data;
  logic [7:0]  pc_out, pc_oe;
  logic        src_valid;
  int fail_count, num_checks, pops, hi_cnt, bad_data, pushes;
  pwe_engine u_dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ctrl_out(ctrl_out), .rdy_in(rdy_in), .wave_addr_out(wave_addr_out),
    .fifo_data_bus_in(bus_in), .fifo_data_bus_out(bus_out), .fifo_data_bus_oe(bus_oe),
    .port_c_in(8'h5A), .port_c_out(pc_out), .port_c_oe(pc_oe), .src_data(16'h00C3),
    .src_valid(src_valid),
    .src_pop(src_pop), .snk_data(snk_data), .snk_push(snk_push), .snk_ready(1'b1),
    .slave_byte(slave_byte), .slave_byte_valid(slave_byte_valid));
  pwe_dev_model u_dev (.core_clk(core_clk), .resetn(resetn), .ctrl_out(ctrl_out),
    .bus_out(bus_out), .bus_oe(bus_oe), .rdy_in(rdy_in), .bus_in(bus_in));
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Monitor strobes, held control level and driven data
  always @(posedge core_clk) begin
    if (ctrl_out === 6'h15) hi_cnt++;
    if (src_pop === 1'b1) pops++;
    if (src_pop === 1'b1 && bus_out[7:0] !== 8'hC3) bad_data++;
    if (snk_push === 1'b1) pushes++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : bus
  task automatic feed(input int n, input logic [7:0] first_b);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      slave_byte       <= (i == 0) ? first_b : 8'h00;
      slave_byte_valid <= 1'b1;
    end
    @(posedge core_clk);
    slave_byte_valid <= 1'b0;
  endtask : feed
  task automatic t_reset;
    chk(ctrl_out, 6'h3F);
    bus(0, 8'h00, 0);
    chk(q, 32'h0000_3F00);
    bus(0, 8'h40, 0);
    chk(q, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_wave;
    int n;
    bus(1, 8'h80, 32'h003C_1055);
    bus(1, 8'h14, 0);
    bus(1, 8'h08, 3);
    bus(0, 8'h08, 0);
    chk(q, 32'h3);
    pops = 0;
    hi_cnt = 0;
    bad_data = 0;
    src_valid <= 1'b0;
    // Mode must already be master when go is written
    bus(1, 8'h00, 32'h3F40);
    bus(1, 8'h00, 32'h3F41);
    repeat (12) @(posedge core_clk);
    chk(pops, 0);
    src_valid <= 1'b1;
    n = 0;
    do begin
      bus(0, 8'h04, 0);
      n++;
    end while (q[1] !== 1'b1 && n < 100);
    chk(q[1:0], 2'b10);
    chk(pops, 3);
    chk(wave_addr_out, 9'h003);
    chk(hi_cnt >= 5, 1);
    chk(bad_data, 0);
    chk(ctrl_out, 6'h3F);
    bus(0, 8'h08, 0);
    chk(q, 32'h0);
    $display("test waveform done");
  endtask : t_wave
  task automatic t_ports;
    bus(1, 8'h10, 32'h00FF_0000);
    repeat (2) @(posedge core_clk);
    chk({pc_oe, pc_out}, 16'hFF03);
    bus(1, 8'h10, 32'h0);
    bus(1, 8'h0C, 32'hF0C3_A55A);
    repeat (2) @(posedge core_clk);
    chk({pc_oe, pc_out}, 16'hA55A);
    chk({bus_oe[15:8], bus_out[15:8]}, 16'hF0C3);
    $display("test ports done");
  endtask : t_ports
  // Undriven lower lines read back as the inverse of the last byte sent
  task automatic t_rx;
    int n;
    bus(1, 8'hA0, 32'h0024_106A);
    bus(1, 8'h08, 1);
    pushes = 0;
    bus(1, 8'h00, 32'h3F43);
    n = 0;
    do begin
      bus(0, 8'h04, 0);
      n++;
    end while (q[1] !== 1'b1 && n < 100);
    chk(pushes, 1);
    chk(snk_data, 16'h003C);
    $display("test receive done");
  endtask : t_rx
  task automatic t_code;
    bus(1, 8'h18, 0);
    feed(256, 8'h01);
    bus(0, 8'h1C, 0);
    chk(q, 32'h00AB_AAAA);
    bus(0, 8'h20, 0);
    chk(q, 32'h0);
    feed(256, 8'h00);
    bus(0, 8'h20, 0);
    chk(q, 32'h00FF_FFFF);
    feed(256, 8'h01);
    bus(0, 8'h20, 0);
    chk(q, 32'h00FF_FFFF);
    bus(1, 8'h00, 32'h3F10);
    bus(1, 8'h18, 0);
    feed(512, 8'h01);
    bus(0, 8'h1C, 0);
    chk(q, 32'h00AA_AAAA);
    bus(1, 8'h00, 32'h3F08);
    bus(1, 8'h18, 0);
    feed(256, 8'h01);
    bus(0, 8'h1C, 0);
    chk(q, 32'h0);
    $display("test code done");
  endtask : t_code
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  initial begin
    {resetn, avs_read, avs_write, slave_byte_valid} = 4'h0;
    {avs_address, slave_byte, avs_writedata} = 48'h0;
    {fail_count, num_checks, pops, hi_cnt, bad_data, pushes} = 192'h0;
    src_valid = 1'b1;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset;
    t_wave;
    t_ports;
    t_rx;
    t_code;
    close_out;
  end
  // Whole run needs a few thousand cycles
  initial begin
    #(20000 * 25);
    fail_count++;
    close_out;
  end
endmodule : programmable_waveform_master_ecc_test
`default_nettype wire

/* File: verif/pwe_dev_model.sv */
// External parallel device model driving the ready inputs and data pins
`timescale 1ns/1ps
`default_nettype none
module pwe_dev_model #(
  parameter int STALL = 5
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Engine side
  input  wire logic [5:0]  ctrl_out,
  input  wire logic [15:0] bus_out,
  input  wire logic [15:0] bus_oe,
  output logic      [5:0]  rdy_in,
  output logic      [15:0] bus_in
);
  logic [7:0] wait_cnt;
  // slow device answers only after STALL cycles of a strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 8'h00;
      rdy_in   <= 6'h00;
    end else if (ctrl_out == 6'h3F) begin
      wait_cnt <= 8'h00;
      rdy_in   <= 6'h00;
    end else if (wait_cnt < STALL) begin
      wait_cnt <= wait_cnt + 8'h01;
    end else begin
      rdy_in <= 6'h01;
    end
  end
  // Undriven lines show the inverse so a stale value never passes
  assign bus_in = (bus_out & bus_oe) | (~bus_out & ~bus_oe);
endmodule : pwe_dev_model
`default_nettype wire
